// >>> hdl/sfdp_rst_pkg.sv
// Package of constants and types for the soft reset and parameter read block
package sfdp_rst_pkg;
   // ------------------------------------------------------------------
   // Opcodes and frame layout
   // ------------------------------------------------------------------
   localparam logic [7:0] OPC_RST_EN   = 8'h66;
   localparam logic [7:0] OPC_RST      = 8'h99;
   localparam logic [7:0] OPC_SFDP     = 8'h5A;
   localparam logic [4:0] SPI_OPC_END  = 5'h07;
   localparam logic [4:0] QUAD_OPC_END = 5'h01;
   localparam logic [4:0] SPI_ADR_END  = 5'h17;
   localparam logic [4:0] QUAD_ADR_END = 5'h05;
   localparam logic [4:0] DUMMY_END    = 5'h07;
   localparam int         SFDP_BYTES   = 2048;
   localparam int         SYNC_STAGES  = 3;
   // ------------------------------------------------------------------
   // Reset recovery time
   // ------------------------------------------------------------------
   localparam int T_RST_NS   = 30000;
   localparam int MCLK_NS    = 40;
   localparam int RST_CYC    = (T_RST_NS + MCLK_NS - 1) / MCLK_NS;
   // ------------------------------------------------------------------
   // Volatile settings and their power-on values
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] vol_status;
      logic       write_enable_latch;
      logic       suspend_flag;
      logic [7:0] cont_read_bits;
      logic       read_dummy_sel;
      logic [1:0] wrap_len;
      logic       wrap_disable_bit;
      logic       four_line_command_mode;
   } vol_s;
   localparam vol_s VOL_DEFAULT = '{vol_status: 2'h0, write_enable_latch: 1'h0,
      suspend_flag: 1'h0, cont_read_bits: 8'h00, read_dummy_sel: 1'h0,
      wrap_len: 2'h0, wrap_disable_bit: 1'h1, four_line_command_mode: 1'h0};
   typedef enum {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_SKIP} link_e;
endpackage

// >>> hdl/sfdp_rom_if.sv
// Interface between the link logic and the parameter area lookup
`timescale 1ns/1ns
interface sfdp_rom_if;
   logic [23:0] addr;
   logic [7:0]  data;
   modport reader (output addr, input data);
   modport rom    (input addr, output data);
endinterface

// >>> hdl/sfdp_rom.sv
// Read-only discoverable parameter area contents
`timescale 1ns/1ns
module sfdp_rom #(
   parameter logic [7:0] MFR_ID = 8'hA5 // Arbitrary neutral value
) (
   sfdp_rom_if.rom rif
);
   always_comb begin
      rif.data = 8'hFF;
      if (rif.addr < 24'(sfdp_rst_pkg::SFDP_BYTES)) begin
         unique case (rif.addr[10:0])
            11'h000: rif.data = 8'h53;
            11'h001: rif.data = 8'h46;
            11'h002: rif.data = 8'h44;
            11'h003: rif.data = 8'h50;
            11'h004: rif.data = 8'h06;
            11'h005: rif.data = 8'h01;
            11'h006: rif.data = 8'h01;
            11'h008: rif.data = 8'h00;
            11'h009: rif.data = 8'h06;
            11'h00A: rif.data = 8'h01;
            11'h00B: rif.data = 8'h10;
            11'h00C: rif.data = 8'h30;
            11'h00D: rif.data = 8'h00;
            11'h00E: rif.data = 8'h00;
            11'h010: rif.data = MFR_ID;
            11'h011: rif.data = 8'h00;
            11'h012: rif.data = 8'h01;
            11'h013: rif.data = 8'h02;
            11'h014: rif.data = 8'h80;
            11'h015: rif.data = 8'h00;
            11'h016: rif.data = 8'h00;
            11'h017: rif.data = 8'h01;
            11'h030: rif.data = 8'hE5;
            11'h031: rif.data = 8'h20;
            11'h032: rif.data = 8'hF1;
            11'h037: rif.data = 8'h01;
            11'h038: rif.data = 8'h44;
            11'h039: rif.data = 8'hEB;
            11'h03A: rif.data = 8'h08;
            11'h03B: rif.data = 8'h6B;
            11'h03C: rif.data = 8'h08;
            11'h03D: rif.data = 8'h3B;
            11'h03E: rif.data = 8'h80;
            11'h03F: rif.data = 8'hBB;
            11'h040: rif.data = 8'hFE;
            11'h046: rif.data = 8'h00;
            default: rif.data = 8'hFF;
         endcase
      end
   end
endmodule // sfdp_rom

// >>> hdl/sfdp_reset_ctrl.sv
// Soft reset sequencer and parameter area read over the serial link
`timescale 1ns/1ns
// Functional notes
// - Reset happens only when 66h is directly followed by 99h.
// - Any opcode other than 66h or 99h after 66h drops the reset-enabled state.
// - Both opcodes are decoded in single-line and four-line mode.
// - An accepted reset aborts internal work and restores power-on state.
// - Accepted reset clears all volatile settings to their defaults.
// - For 30 us after reset every instruction is ignored.
// - Parameter area is 2048 read-only bytes, unused bytes read FFh.
// - Parameter read is opcode 5Ah, 24-bit address, 8 dummy clocks.
// - Data bytes leave from the given address, bits change on falling clock.
// - Chip-select high ends the read and releases the output at once.
// - Header holds signature, revisions, header count and FFh at 07h.
// - Headers point to tables at 30h (10h dwords) and 80h (02h dwords).
// - Byte 30h reads E5h and byte 31h reads 20h.
// - After reset read parameters return to 8-byte wrap and 4 dummy clocks.
// - Wrap-disable bit comes up set at power-on.
module sfdp_reset_ctrl #(
   parameter int RST_CYCLES = sfdp_rst_pkg::RST_CYC
) (
   input  wire logic               mclk_i,
   input  wire logic               nrst_i,
   input  wire logic               sck_i,
   input  wire logic               csn_i,
   input  wire logic [3:0]         io_i,
   output logic      [3:0]         io_o,
   output logic      [3:0]         io_oe_o,
   input  wire logic               set_load_i,
   input  wire sfdp_rst_pkg::vol_s set_val_i,
   output sfdp_rst_pkg::vol_s      vol_o,
   output logic                    abort_o,
   output logic                    reset_busy_o
);
   localparam int CW = $clog2(RST_CYCLES + 1);
   initial begin
      if (RST_CYCLES < 1 || RST_CYCLES > 65535) begin
         $error("RST_CYCLES out of range");
      end
   end

   sfdp_rom_if rif ();
   sfdp_rom u_rom (.rif(rif));

   // ------------------------------------------------------------------
   // Link side, rising edge: command, address and dummy phases
   // ------------------------------------------------------------------
   sfdp_rst_pkg::link_e st_r, st_nxt;
   logic [4:0]  cnt_r, cnt_nxt;
   logic [23:0] sh_r, sh_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic [7:0]  opc_r, opc_nxt;
   logic        tgl_r, tgl_nxt;
   logic        lrst_n_r;
   logic [sfdp_rst_pkg::SYNC_STAGES-1:0] bsync_r, qsync_r;
   logic        busy_l_r, quad_l_r;
   logic        last;

   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r + 5'h01;
      addr_nxt = addr_r;
      opc_nxt  = opc_r;
      tgl_nxt  = tgl_r;
      last     = 1'b0;
      sh_nxt   = quad_l_r ? {sh_r[19:0], io_i} : {sh_r[22:0], io_i[0]};
      unique case (st_r)
         sfdp_rst_pkg::ST_OPC: begin
            last = (cnt_r == (quad_l_r ? sfdp_rst_pkg::QUAD_OPC_END
                                       : sfdp_rst_pkg::SPI_OPC_END));
            if (last) begin
               cnt_nxt = 5'h00;
               opc_nxt = sh_nxt[7:0];
               // While recovering, opcodes are swallowed here
               tgl_nxt = busy_l_r ? tgl_r : ~tgl_r;
               st_nxt  = (!busy_l_r && sh_nxt[7:0] == sfdp_rst_pkg::OPC_SFDP)
                         ? sfdp_rst_pkg::ST_ADDR : sfdp_rst_pkg::ST_SKIP;
            end
         end
         sfdp_rst_pkg::ST_ADDR: begin
            last = (cnt_r == (quad_l_r ? sfdp_rst_pkg::QUAD_ADR_END
                                       : sfdp_rst_pkg::SPI_ADR_END));
            if (last) begin
               cnt_nxt  = 5'h00;
               addr_nxt = sh_nxt;
               st_nxt   = sfdp_rst_pkg::ST_DUMMY;
            end
         end
         sfdp_rst_pkg::ST_DUMMY: begin
            if (cnt_r == sfdp_rst_pkg::DUMMY_END) begin
               st_nxt = sfdp_rst_pkg::ST_DATA;
            end
         end
         sfdp_rst_pkg::ST_DATA,
         sfdp_rst_pkg::ST_SKIP: cnt_nxt = cnt_r;
      endcase
   end

   // Frame state is cleared by deselect, so no edge is needed after a frame
   always_ff @(posedge sck_i or posedge csn_i) begin
      if (csn_i) begin
         st_r   <= sfdp_rst_pkg::ST_OPC;
         cnt_r  <= 5'h00;
         sh_r   <= 24'h000000;
         addr_r <= 24'h000000;
      end else begin
         st_r   <= st_nxt;
         cnt_r  <= cnt_nxt;
         sh_r   <= sh_nxt;
         addr_r <= addr_nxt;
      end
   end

   // Toggle and opcode must survive deselect; only device reset clears them
   // Busy and mode levels only move on link edges: the host must give a few
   // edges under deselect before a frame that depends on a fresh level
   always_ff @(posedge sck_i or negedge lrst_n_r) begin
      if (!lrst_n_r) begin
         opc_r    <= 8'h00;
         tgl_r    <= 1'b0;
         bsync_r  <= '0;
         qsync_r  <= '0;
         busy_l_r <= 1'b0;
         quad_l_r <= 1'b0;
      end else begin
         opc_r    <= opc_nxt;
         tgl_r    <= tgl_nxt;
         bsync_r  <= {bsync_r[sfdp_rst_pkg::SYNC_STAGES-2:0], reset_busy_o};
         qsync_r  <= {qsync_r[sfdp_rst_pkg::SYNC_STAGES-2:0],
                      vol_o.four_line_command_mode};
         if (bsync_r[1] == bsync_r[2]) begin
            busy_l_r <= bsync_r[2];
         end
         if (qsync_r[1] == qsync_r[2]) begin
            quad_l_r <= qsync_r[2];
         end
      end
   end

   // ------------------------------------------------------------------
   // Link side, falling edge: parameter data out
   // ------------------------------------------------------------------
   logic [23:0] ptr_r, ptr_nxt;
   logic [2:0]  bitc_r, bitc_nxt;
   logic [3:0]  io_nxt, oe_nxt;

   assign rif.addr = ptr_r;

   always_comb begin
      ptr_nxt  = addr_r;
      bitc_nxt = 3'h0;
      io_nxt   = 4'h0;
      oe_nxt   = 4'h0;
      if (st_r == sfdp_rst_pkg::ST_DATA) begin
         ptr_nxt = ptr_r;
         if (quad_l_r) begin
            io_nxt   = bitc_r[2] ? rif.data[3:0] : rif.data[7:4];
            oe_nxt   = 4'hF;
            bitc_nxt = bitc_r + 3'h4;
            if (bitc_r[2]) begin
               ptr_nxt = ptr_r + 24'h000001;
            end
         end else begin
            io_nxt   = {2'h0, rif.data[3'h7 - bitc_r], 1'b0};
            oe_nxt   = 4'h2;
            bitc_nxt = bitc_r + 3'h1;
            if (bitc_r == 3'h7) begin
               ptr_nxt = ptr_r + 24'h000001;
            end
         end
      end
   end

   always_ff @(negedge sck_i or posedge csn_i) begin
      if (csn_i) begin
         ptr_r   <= 24'h000000;
         bitc_r  <= 3'h0;
         io_o    <= 4'h0;
         io_oe_o <= 4'h0;
      end else begin
         ptr_r   <= ptr_nxt;
         bitc_r  <= bitc_nxt;
         io_o    <= io_nxt;
         io_oe_o <= oe_nxt;
      end
   end

   // ------------------------------------------------------------------
   // System side: opcode arrival, reset sequence, volatile settings
   // ------------------------------------------------------------------
   logic [sfdp_rst_pkg::SYNC_STAGES-1:0] tsync_r;
   logic          seen_r, seen_nxt, evt, accept;
   logic          en_r, en_nxt;
   logic          abort_nxt, busy_r, busy_nxt;
   logic [CW-1:0] rcnt_r, rcnt_nxt;
   sfdp_rst_pkg::vol_s vol_nxt;

   // Opcode is read a few cycles after the toggle; frames must be spaced
   // by more than the sync delay for the byte to still be stable
   assign evt = (tsync_r[1] == tsync_r[2]) && (tsync_r[2] != seen_r);
   assign accept = evt && !busy_r && en_r && opc_r == sfdp_rst_pkg::OPC_RST;

   always_comb begin
      seen_nxt  = evt ? tsync_r[2] : seen_r;
      en_nxt    = en_r;
      vol_nxt   = vol_o;
      abort_nxt = 1'b0;
      rcnt_nxt  = busy_r ? rcnt_r - CW'(1) : rcnt_r;
      if (set_load_i && !busy_r) begin
         vol_nxt = set_val_i;
      end
      if (accept) begin
         abort_nxt = 1'b1;
         vol_nxt   = sfdp_rst_pkg::VOL_DEFAULT;
         rcnt_nxt  = CW'(RST_CYCLES);
         en_nxt    = 1'b0;
      end else if (evt && !busy_r) begin
         en_nxt = (opc_r == sfdp_rst_pkg::OPC_RST_EN);
      end
      busy_nxt = (rcnt_nxt != '0);
   end

   always_ff @(posedge mclk_i) begin
      lrst_n_r <= nrst_i;
      if (!nrst_i) begin
         tsync_r <= '0;
         seen_r  <= 1'b0;
         en_r    <= 1'b0;
         vol_o   <= sfdp_rst_pkg::VOL_DEFAULT;
         abort_o <= 1'b0;
         busy_r  <= 1'b0;
         rcnt_r  <= '0;
      end else begin
         tsync_r <= {tsync_r[sfdp_rst_pkg::SYNC_STAGES-2:0], tgl_r};
         seen_r  <= seen_nxt;
         en_r    <= en_nxt;
         vol_o   <= vol_nxt;
         abort_o <= abort_nxt;
         busy_r  <= busy_nxt;
         rcnt_r  <= rcnt_nxt;
      end
   end
   assign reset_busy_o = busy_r;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   logic [15:0] blen_r;
   always_ff @(posedge mclk_i) begin
      blen_r <= (!nrst_i || !busy_r) ? 16'h0000 : blen_r + 16'h0001;
   end

   AST_RESET_NEEDS_ENABLE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $rose(abort_o) |-> $past(en_r) && $past(opc_r) == sfdp_rst_pkg::OPC_RST)
      else $error("reset accepted without enable");
   AST_OTHER_CLEARS_ENABLE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      evt && !busy_r && opc_r != sfdp_rst_pkg::OPC_RST_EN |=> !en_r)
      else $error("enable survived another opcode");
   AST_POWERON_STATE: assert property (@(posedge mclk_i)
      $past(!nrst_i) && nrst_i |-> !en_r && vol_o == sfdp_rst_pkg::VOL_DEFAULT)
      else $error("bad power-on state");
   AST_RESET_DEFAULTS: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      abort_o |-> vol_o == sfdp_rst_pkg::VOL_DEFAULT && !vol_o.read_dummy_sel
                  && vol_o.wrap_disable_bit && reset_busy_o)
      else $error("settings not at default after reset");
   AST_ABORT_ONE_PULSE: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      abort_o |=> !abort_o [*3])
      else $error("abort longer than one cycle");
   AST_BUSY_LENGTH: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      $fell(busy_r) |-> blen_r == 16'(RST_CYCLES))
      else $error("reset recovery length wrong");
   AST_BUSY_IGNORES: assert property (@(posedge mclk_i) disable iff (!nrst_i)
      evt && busy_r |=> $stable(en_r) && !abort_o)
      else $error("opcode acted on while busy");
   AST_DUMMY_COUNT: assert property (@(posedge sck_i) disable iff (csn_i)
      st_r == sfdp_rst_pkg::ST_DATA && $past(st_r) == sfdp_rst_pkg::ST_DUMMY
      |-> $past(st_r, 8) == sfdp_rst_pkg::ST_DUMMY
          && $past(st_r, 9) == sfdp_rst_pkg::ST_ADDR)
      else $error("dummy phase length wrong");
   AST_OUT_ONLY_IN_DATA: assert property (@(negedge sck_i) disable iff (csn_i)
      io_oe_o != 4'h0 |-> st_r == sfdp_rst_pkg::ST_DATA)
      else $error("output driven outside data phase");
   AST_ROM_SIGNATURE: assert property (@(posedge mclk_i)
      rif.addr == 24'h000003 |-> rif.data == 8'h50)
      else $error("signature byte wrong");
   AST_ROM_BLANK: assert property (@(posedge mclk_i)
      rif.addr >= 24'h000800 |-> rif.data == 8'hFF)
      else $error("area outside 2048 bytes not blank");

   COV_RESET: cover property (@(posedge mclk_i) disable iff (!nrst_i) $rose(abort_o));
   COV_ENABLE_DROPPED: cover property (@(posedge mclk_i) disable iff (!nrst_i)
      $fell(en_r) && !abort_o);
   COV_BUSY_IGNORE: cover property (@(posedge mclk_i) disable iff (!nrst_i) evt && busy_r);
   COV_DATA_OUT: cover property (@(negedge sck_i) disable iff (csn_i) io_oe_o == 4'h2);
endmodule // sfdp_reset_ctrl

// >>> verification/sfdp_host_model.sv
// Host controller model that frames commands and parameter reads on the serial link
`timescale 1ns/1ns
module sfdp_host_model (
   output logic            sck_o,
   output logic            csn_o,
   output logic      [3:0] io_o,
   input  wire logic [3:0] io_i,
   input  wire logic [3:0] oe_i
);
   logic [7:0] dq [0:31];
   int         oe_err;

   initial begin
      sck_o  = 1'b0;
      csn_o  = 1'b1;
      io_o   = 4'h0;
      oe_err = 0;
   end

   // ---------------------------------------------------------------
   // Bit level framing, 80 ns link period, clock idles low
   // ---------------------------------------------------------------
   task automatic put(input logic quad, input logic [31:0] v, input int nb);
      int i;
      for (i = nb - 1; i >= 0; i -= (quad ? 4 : 1)) begin
         // Unused lines toggle so a stale level never passes for data
         if (quad) io_o = v[i -: 4];
         else io_o = {~io_o[3:1], v[i]};
         #40 sck_o = 1'b1;
         #40 sck_o = 1'b0;
      end
   endtask

   // Gap keeps the opcode spacing and covers the reset interval start
   // Busy and mode levels reach the link side on link edges, so a few
   // edges under deselect let them settle before the opcode
   task automatic open_frame();
      repeat (4) begin
         #40 sck_o = 1'b1;
         #40 sck_o = 1'b0;
      end
      #80 csn_o = 1'b0;
      #40;
   endtask

   task automatic close_frame();
      #20 csn_o = 1'b1;
      io_o = ~io_o;
      #1;
   endtask

   task automatic cmd(input logic quad, input logic [7:0] opc);
      open_frame();
      put(quad, {24'h0, opc}, 8);
      close_frame();
   endtask

   task automatic rd(input logic quad, input logic [23:0] a, input int nbits);
      int k;
      int w;
      w = quad ? 4 : 1;
      open_frame();
      put(quad, {24'h0, 8'h5A}, 8);
      put(quad, {8'h0, a}, 24);
      put(1'b0, 32'h0, 8);
      oe_err = 0;
      for (k = 0; k < nbits; k += w) begin
         io_o = ~io_o;
         #40 sck_o = 1'b1;
         if (quad) dq[k / 8][(7 - (k % 8)) -: 4] = io_i;
         else dq[k / 8][7 - (k % 8)] = io_i[1];
         if (oe_i !== (quad ? 4'hF : 4'h2)) oe_err++;
         #40 sck_o = 1'b0;
      end
      close_frame();
   endtask
endmodule // sfdp_host_model

// >>> verification/soft_reset_and_discovery_read_tb.sv
// Self-checking bench for the soft reset sequencer and parameter area read
`timescale 1ns/1ns
module soft_reset_and_discovery_read_tb;
   localparam int RC = 200;
   logic               mclk_i     = 1'b0;
   logic               nrst_i     = 1'b0;
   logic               set_load_i = 1'b0;
   sfdp_rst_pkg::vol_s set_val_i  = '0;
   sfdp_rst_pkg::vol_s vol_o;
   logic               sck_i;
   logic               csn_i;
   logic [3:0]         io_i;
   logic [3:0]         io_o;
   logic [3:0]         io_oe_o;
   logic               abort_o;
   logic               reset_busy_o;
   int                 err_total  = 0;
   int                 n_checks   = 0;
   int                 n_abort    = 0;
   int                 n_busy     = 0;
   int                 j;
   // Byte 10h holds the arbitrary neutral maker value of the lookup
   logic [7:0]         hdr [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h01,
      8'hFF, 8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hFF, 8'hA5, 8'h00,
      8'h01, 8'h02, 8'h80, 8'h00, 8'h00, 8'h01};

   always #20 mclk_i = ~mclk_i;

   always @(posedge mclk_i) begin
      if (abort_o === 1'b1) n_abort++;
      if (reset_busy_o === 1'b1) n_busy++;
   end

   sfdp_reset_ctrl #(.RST_CYCLES(RC)) i_dut (
      .mclk_i      (mclk_i),
      .nrst_i      (nrst_i),
      .sck_i       (sck_i),
      .csn_i       (csn_i),
      .io_i        (io_i),
      .io_o        (io_o),
      .io_oe_o     (io_oe_o),
      .set_load_i  (set_load_i),
      .set_val_i   (set_val_i),
      .vol_o       (vol_o),
      .abort_o     (abort_o),
      .reset_busy_o(reset_busy_o)
   );

   sfdp_host_model i_host (
      .sck_o(sck_i),
      .csn_o(csn_i),
      .io_o (io_i),
      .io_i (io_o),
      .oe_i (io_oe_o)
   );

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic stop_test();
      $display("Checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic load(input logic [16:0] v);
      @(posedge mclk_i);
      set_val_i  <= v;
      set_load_i <= 1'b1;
      @(posedge mclk_i);
      set_load_i <= 1'b0;
      @(posedge mclk_i);
      #1;
   endtask

   task automatic wait_busy(input logic lvl, input int lim);
      int i;
      for (i = 0; i < lim && reset_busy_o !== lvl; i++) @(posedge mclk_i);
      if (reset_busy_o !== lvl) begin
         err_total++;
         stop_test();
      end
   endtask

   // Accepted reset: abort, defaults, refusal while busy, busy length
   task automatic rst_seq(input int n_ab);
      n_busy = 0;
      wait_busy(1'b1, 50);
      repeat (2) @(posedge mclk_i);
      #1;
      chk("abort", n_abort, n_ab);
      chk("vol", vol_o, sfdp_rst_pkg::VOL_DEFAULT);
      load(17'h1FFFF);
      chk("vol_busy", vol_o, sfdp_rst_pkg::VOL_DEFAULT);
      i_host.rd(1'b0, 24'h0, 8);
      chk("oe_busy", i_host.oe_err, 8);
      wait_busy(1'b0, RC + 50);
      chk("busy_len", n_busy, RC);
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      #1;
      chk("vol_por", vol_o, sfdp_rst_pkg::VOL_DEFAULT);
      chk("busy_por", reset_busy_o, 0);
      load(17'h0A5A4);
      chk("vol_load", vol_o, 17'h0A5A4);
      i_host.cmd(1'b0, sfdp_rst_pkg::OPC_RST);
      repeat (10) @(posedge mclk_i);
      chk("abort_first", n_abort, 0);
      i_host.cmd(1'b0, sfdp_rst_pkg::OPC_RST_EN);
      i_host.cmd(1'b0, 8'h05);
      i_host.cmd(1'b0, sfdp_rst_pkg::OPC_RST);
      repeat (10) @(posedge mclk_i);
      chk("abort_broken", n_abort, 0);
      chk("vol_kept", vol_o, 17'h0A5A4);
      i_host.cmd(1'b0, sfdp_rst_pkg::OPC_RST_EN);
      i_host.cmd(1'b0, sfdp_rst_pkg::OPC_RST);
      rst_seq(1);
      load(17'h05A5B);
      chk("quad_on", vol_o, 17'h05A5B);
      // Four-line parameter read: high nibble first, all lines driven
      i_host.rd(1'b1, 24'h0, 32);
      chk("oe_quad", i_host.oe_err, 0);
      for (j = 0; j < 4; j++) begin
         chk($sformatf("quad_%0d", j), i_host.dq[j], hdr[j]);
      end
      i_host.cmd(1'b1, sfdp_rst_pkg::OPC_RST_EN);
      i_host.cmd(1'b1, sfdp_rst_pkg::OPC_RST);
      rst_seq(2);
      i_host.rd(1'b0, 24'h0, 24 * 8);
      chk("oe_hdr", i_host.oe_err, 0);
      for (j = 0; j < 24; j++) begin
         chk($sformatf("hdr_%0h", j), i_host.dq[j], hdr[j]);
      end
      i_host.rd(1'b0, 24'h30, 16);
      chk("tbl_30", i_host.dq[0], 8'hE5);
      chk("tbl_31", i_host.dq[1], 8'h20);
      // Burst across the end of the area must keep reading erased bytes
      i_host.rd(1'b0, 24'h7FE, 32);
      for (j = 0; j < 4; j++) begin
         chk($sformatf("end_%0d", j), i_host.dq[j], 8'hFF);
      end
      i_host.rd(1'b0, 24'h30, 3);
      chk("oe_cut", io_oe_o, 4'h0);
      chk("oe_cut_bits", i_host.oe_err, 0);
      stop_test();
   end
endmodule // soft_reset_and_discovery_read_tb
